// file: rtl/tfs_map.svh
// Register offsets, field positions and reset values of the timer 0 flag and sync block
`ifndef TFS_MAP_SVH
`define TFS_MAP_SVH
`define TFS_OFS_FLAGS      8'h35
`define TFS_OFS_SYNC       8'h43
`define TFS_OFS_COUNT      8'h46
`define TFS_OFS_CMP_A      8'h47
`define TFS_OFS_CMP_B      8'h48
`define TFS_OFS_ENABLES    8'h6E
`define TFS_IO_ALIAS       8'h20
`define TFS_IO_LIMIT       8'h60
`define TFS_BIT_OVF        0
`define TFS_BIT_CMP_A      1
`define TFS_BIT_CMP_B      2
`define TFS_BIT_PSR_SYNC   0
`define TFS_BIT_PSR_ASYNC  1
`define TFS_BIT_HOLD       7
`define TFS_RST_BYTE       8'h00
`define TFS_MAX_COUNT      8'hFF
`endif

// file: rtl/tfs_pkg.sv
// Types shared by the timer 0 flag and sync block
package tfs_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       io_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tfs_bus_t;

    typedef struct packed {
        logic [2:0] ack;
    } tfs_vec_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [2:0] flags;
        logic [2:0] enables;
        logic       hold;
        logic [1:0] psr;
        logic       block_match;
        logic [7:0] rdata;
    } tfs_state_t;
endpackage : tfs_pkg

// file: rtl/tfs_timer0.sv
// Timer 0 counter, compare, flag and prescaler sync register logic
//
// Behaviour
// - Compare-B interrupt enabled by mask bit 2 together with global enable.
// - Compare-A interrupt enabled by mask bit 1 together with global enable.
// - Overflow interrupt enabled by mask bit 0 together with global enable.
// - A request stands only while flag, enable and global enable are set.
// - While hold bit 7 is one, both prescaler reset bits keep written values.
// - Writing hold to zero clears both prescaler reset bits so timers start together.
// - Sync prescaler reset bit 0 resets shared prescaler, self-clears unless holding.
// - Counter register reads and writes the 8-bit count directly.
// - A counter write blocks a compare match on the next timer clock.
// - Both compare registers are matched against the counter every timer clock but the first after a counter write.
// - Compare-B flag bit 2 set on match, cleared by vector or writing one.
// - Compare-A flag bit 1 set on match, cleared by vector or writing one.
// - Overflow flag bit 0 set on overflow, cleared by vector or writing one.
// - Low registers also decode at an alias 0x20 below their data offset.
`timescale 1ns/1ns
`include "tfs_map.svh"
module tfs_timer0
    import tfs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Register bus from the core
    input  wire tfs_bus_t   bus,
    output logic      [7:0] rdata,
    // Timer clock tick and overflow point from the clock select and mode logic
    input  wire logic       timer_tick,
    input  wire logic       overflow_event,
    // Core status and vector acknowledge
    input  wire logic       global_irq_en,
    input  wire tfs_vec_t   vec,
    // Requests, match strobes, prescaler reset bits and counter value
    output logic            irq_ovf,
    output logic            irq_cmp_a,
    output logic            irq_cmp_b,
    output logic            match_a,
    output logic            match_b,
    output logic            sync_prescaler_reset,
    output logic            async_prescaler_reset,
    output logic      [7:0] count_value
);
    tfs_state_t s_q, s_d;
    logic [7:0] daddr;
    logic       hit_flags, hit_sync, hit_count, hit_cmp_a, hit_cmp_b, hit_en;
    logic       wr_en;
    logic [2:0] set_ev, clr_ev;

    always_comb begin
        // Alias decode; extended space has no alias window
        daddr = bus.io_space ? 8'(bus.addr + `TFS_IO_ALIAS) : bus.addr;
        wr_en = bus.wr && !(bus.io_space && bus.addr >= 8'(`TFS_IO_LIMIT - `TFS_IO_ALIAS));
        hit_flags = daddr == `TFS_OFS_FLAGS;
        hit_sync  = daddr == `TFS_OFS_SYNC;
        hit_count = daddr == `TFS_OFS_COUNT;
        hit_cmp_a = daddr == `TFS_OFS_CMP_A;
        hit_cmp_b = daddr == `TFS_OFS_CMP_B;
        hit_en    = daddr == `TFS_OFS_ENABLES && !bus.io_space;
    end

    always_comb begin
        s_d = s_q;
        match_a = timer_tick && !s_q.block_match && s_q.count == s_q.cmp_a;
        match_b = timer_tick && !s_q.block_match && s_q.count == s_q.cmp_b;
        set_ev = '0;
        set_ev[`TFS_BIT_OVF]   = overflow_event;
        set_ev[`TFS_BIT_CMP_A] = match_a;
        set_ev[`TFS_BIT_CMP_B] = match_b;
        // Zero bits of a flag write leave flags alone
        clr_ev = vec.ack | ((wr_en && hit_flags) ? bus.wdata[2:0] : 3'h0);
        // Set wins over a clear in the same cycle
        s_d.flags = (s_q.flags & ~clr_ev) | set_ev;
        // Block window lasts until the next timer clock
        if (timer_tick) begin
            s_d.block_match = 1'b0;
        end
        if (timer_tick) begin
            s_d.count = 8'(s_q.count + 8'h01);
        end
        if (!s_q.hold) begin
            s_d.psr = 2'b00;
        end
        if (wr_en) begin
            if (hit_count) begin
                s_d.count = bus.wdata;
                s_d.block_match = 1'b1;
            end
            if (hit_cmp_a) s_d.cmp_a = bus.wdata;
            if (hit_cmp_b) s_d.cmp_b = bus.wdata;
            if (hit_en) s_d.enables = bus.wdata[2:0];
            if (hit_sync) begin
                s_d.hold = bus.wdata[`TFS_BIT_HOLD];
                // Written one is seen for a cycle even without hold
                s_d.psr = bus.wdata[`TFS_BIT_PSR_ASYNC:`TFS_BIT_PSR_SYNC] |
                          (bus.wdata[`TFS_BIT_HOLD] ? s_q.psr : 2'b00);
            end
        end
        s_d.rdata = `TFS_RST_BYTE;
        if (bus.rd) begin
            case (1'b1)
                hit_flags: s_d.rdata = {5'h00, s_q.flags};
                hit_sync:  s_d.rdata = {s_q.hold, 5'h00, s_q.psr};
                hit_count: s_d.rdata = s_q.count;
                hit_cmp_a: s_d.rdata = s_q.cmp_a;
                hit_cmp_b: s_d.rdata = s_q.cmp_b;
                hit_en:    s_d.rdata = {5'h00, s_q.enables};
                default:   s_d.rdata = `TFS_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign irq_ovf   = global_irq_en && s_q.enables[`TFS_BIT_OVF] && s_q.flags[`TFS_BIT_OVF];
    assign irq_cmp_a = global_irq_en && s_q.enables[`TFS_BIT_CMP_A]
                       && s_q.flags[`TFS_BIT_CMP_A];
    assign irq_cmp_b = global_irq_en && s_q.enables[`TFS_BIT_CMP_B]
                       && s_q.flags[`TFS_BIT_CMP_B];
    assign sync_prescaler_reset  = s_q.psr[`TFS_BIT_PSR_SYNC];
    assign async_prescaler_reset = s_q.psr[`TFS_BIT_PSR_ASYNC];
    assign count_value = s_q.count;
    assign rdata = s_q.rdata;

    property p_irq_b;
        @(posedge clk_sys) disable iff (!rst_b)
        irq_cmp_b == (global_irq_en && s_q.enables[2] && s_q.flags[2]);
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("cmp b request wrong");

    property p_irq_a;
        @(posedge clk_sys) disable iff (!rst_b)
        !global_irq_en |-> !irq_cmp_a;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("cmp a request without global");

    property p_irq_ovf;
        @(posedge clk_sys) disable iff (!rst_b)
        (global_irq_en && s_q.enables[0] && s_q.flags[0]) |-> irq_ovf;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request missing");

    property p_no_flag_no_irq;
        @(posedge clk_sys) disable iff (!rst_b)
        !s_q.flags[1] |-> !irq_cmp_a;
    endproperty
    a_no_flag_no_irq: assert property (p_no_flag_no_irq) else $error("request w/o flag");

    sequence s_hold_write;
        wr_en && hit_sync && bus.wdata[7] && bus.wdata[0];
    endsequence
    property p_hold_keeps;
        @(posedge clk_sys) disable iff (!rst_b)
        s_hold_write ##1 !(wr_en && hit_sync) |=> sync_prescaler_reset;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) else $error("reset bit lost in hold");

    property p_release;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && hit_sync && !bus.wdata[7] && bus.wdata[1:0] == 2'b00)
        |=> (s_q.psr == 2'b00 && !s_q.hold);
    endproperty
    a_release: assert property (p_release) else $error("release left reset bits");

    property p_self_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        (sync_prescaler_reset && !s_q.hold && !(wr_en && hit_sync)) |=> !sync_prescaler_reset;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset bit stuck");

    property p_count_write;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && hit_count) |=> count_value == $past(bus.wdata);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost");

    property p_block;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && hit_count) ##1 timer_tick |-> !match_a && !match_b;
    endproperty
    a_block: assert property (p_block) else $error("match after count write");

    property p_match_flag;
        @(posedge clk_sys) disable iff (!rst_b)
        match_a |=> s_q.flags[1];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("cmp a flag not set");

    property p_w1c;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && hit_flags && bus.wdata[2] && !match_b && !vec.ack[2]) |=> !s_q.flags[2];
    endproperty
    a_w1c: assert property (p_w1c) else $error("cmp b flag not cleared");

    property p_w0_keeps;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_q.flags[0] && wr_en && hit_flags && !bus.wdata[0] && !vec.ack[0]) |=> s_q.flags[0];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost on zero write");

    property p_alias;
        @(posedge clk_sys) disable iff (!rst_b)
        (bus.wr && bus.io_space && bus.addr == 8'h27) |=> s_q.cmp_a == $past(bus.wdata);
    endproperty
    a_alias: assert property (p_alias) else $error("alias write missed");

    sequence s_count_write;
        wr_en && hit_count;
    endsequence
    property p_block_gap;
        @(posedge clk_sys) disable iff (!rst_b)
        s_count_write ##1 !timer_tick ##1 timer_tick |-> !match_a && !match_b;
    endproperty
    a_block_gap: assert property (p_block_gap) else $error("match after count write");

    // Only the first timer clock after a count write loses its match
    property p_block_ends;
        @(posedge clk_sys) disable iff (!rst_b)
        s_count_write ##1 (timer_tick && !(wr_en && hit_count))
        ##1 (timer_tick && count_value == s_q.cmp_a) |-> match_a;
    endproperty
    a_block_ends: assert property (p_block_ends) else $error("match lost after block");

    property p_match_b_flag;
        @(posedge clk_sys) disable iff (!rst_b)
        match_b |=> s_q.flags[2];
    endproperty
    a_match_b_flag: assert property (p_match_b_flag) else $error("cmp b flag not set");

    property p_ovf_flag;
        @(posedge clk_sys) disable iff (!rst_b)
        overflow_event |=> s_q.flags[0];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_vec_clear_a;
        @(posedge clk_sys) disable iff (!rst_b)
        (vec.ack[1] && !match_a) |=> !s_q.flags[1];
    endproperty
    a_vec_clear_a: assert property (p_vec_clear_a) else $error("vector left cmp a flag");

    property p_w1c_ovf;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && hit_flags && bus.wdata[0] && !overflow_event) |=> !s_q.flags[0];
    endproperty
    a_w1c_ovf: assert property (p_w1c_ovf) else $error("overflow flag not cleared");

    property p_w0_keeps_b;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_q.flags[2] && wr_en && hit_flags && !bus.wdata[2] && !vec.ack[2]) |=> s_q.flags[2];
    endproperty
    a_w0_keeps_b: assert property (p_w0_keeps_b) else $error("flag lost on zero write");

    property p_irq_b_gate;
        @(posedge clk_sys) disable iff (!rst_b)
        !global_irq_en |-> !irq_cmp_b && !irq_ovf;
    endproperty
    a_irq_b_gate: assert property (p_irq_b_gate) else $error("request without global");

    property p_irq_a_on;
        @(posedge clk_sys) disable iff (!rst_b)
        (global_irq_en && s_q.enables[1] && s_q.flags[1]) |-> irq_cmp_a;
    endproperty
    a_irq_a_on: assert property (p_irq_a_on) else $error("cmp a request missing");

    property p_no_en_irq;
        @(posedge clk_sys) disable iff (!rst_b)
        (!s_q.enables[0] || !s_q.flags[0]) |-> !irq_ovf;
    endproperty
    a_no_en_irq: assert property (p_no_en_irq) else $error("request w/o enable");

    property p_no_flag_b;
        @(posedge clk_sys) disable iff (!rst_b)
        !s_q.flags[2] |-> !irq_cmp_b;
    endproperty
    a_no_flag_b: assert property (p_no_flag_b) else $error("cmp b request w/o flag");

    property p_hold_keeps_all;
        @(posedge clk_sys) disable iff (!rst_b)
        (s_q.hold && !(wr_en && hit_sync)) |=> $stable(s_q.psr);
    endproperty
    a_hold_keeps_all: assert property (p_hold_keeps_all) else $error("held bits moved");

    sequence s_sync_release;
        wr_en && hit_sync && !bus.wdata[7];
    endsequence
    // A reset bit written with the release shows for one cycle only
    property p_release_late;
        @(posedge clk_sys) disable iff (!rst_b)
        s_sync_release ##1 !(wr_en && hit_sync) |=> s_q.psr == 2'b00 && !s_q.hold;
    endproperty
    a_release_late: assert property (p_release_late) else $error("release kept bits");

    property p_count_still;
        @(posedge clk_sys) disable iff (!rst_b)
        (!timer_tick && !(wr_en && hit_count)) |=> $stable(count_value);
    endproperty
    a_count_still: assert property (p_count_still) else $error("count moved without tick");

    property p_count_read;
        @(posedge clk_sys) disable iff (!rst_b)
        (bus.rd && hit_count) |=> rdata == $past(count_value);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");

    // Extended registers have no alias, so alias writes above the window are dropped
    property p_alias_limit;
        @(posedge clk_sys) disable iff (!rst_b)
        (bus.wr && bus.io_space && bus.addr >= 8'(`TFS_IO_LIMIT - `TFS_IO_ALIAS))
        |=> $stable(s_q.enables);
    endproperty
    a_alias_limit: assert property (p_alias_limit) else $error("alias write taken");

    // Read data stands one cycle and is zero otherwise
    property p_rdata_idle;
        @(posedge clk_sys) disable iff (!rst_b)
        !bus.rd |=> rdata == `TFS_RST_BYTE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");
endmodule : tfs_timer0

// file: verification/tfs_core_model.sv
// Processor core side: takes pending timer vectors after a set delay
`timescale 1ns/1ns
module tfs_core_model
    import tfs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Requests and vector control
    input  wire logic       irq_ovf,
    input  wire logic       irq_cmp_a,
    input  wire logic       irq_cmp_b,
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    output tfs_vec_t        vec
);
    logic [3:0] wait_q;
    logic       busy_q;
    logic       cool_q;

    // Cool-down cycle: the flag drops only one edge after the vector pulse
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 4'h0;
            busy_q <= 1'b0;
            cool_q <= 1'b0;
            vec    <= '0;
        end else begin
            vec    <= '0;
            cool_q <= 1'b0;
            if (busy_q) begin
                if (wait_q != 4'h0) begin
                    wait_q <= wait_q - 4'h1;
                end else begin
                    busy_q <= 1'b0;
                    cool_q <= 1'b1;
                    vec.ack <= irq_cmp_a ? 3'h2 : irq_cmp_b ? 3'h4 : {2'h0, irq_ovf};
                end
            end else if (ack_en && !cool_q && (irq_ovf | irq_cmp_a | irq_cmp_b)) begin
                busy_q <= 1'b1;
                wait_q <= ack_delay;
            end
        end
    end
endmodule : tfs_core_model

// file: verification/test_tfs_timer0.sv
// Register-level testbench of the timer 0 flag and sync block
`timescale 1ns/1ns
`include "tfs_map.svh"
module test_tfs_timer0
    import tfs_pkg::*;
;
    logic       clk_sys, rst_b, timer_tick, overflow_event, global_irq_en, ack_en;
    logic       irq_ovf, irq_cmp_a, irq_cmp_b, match_a, match_b, hit_a, hit_b;
    logic       sync_prescaler_reset, async_prescaler_reset;
    logic [3:0] ack_delay;
    logic [7:0] rdata, count_value;
    tfs_bus_t   bus;
    tfs_vec_t   vec;
    int         err_total, tests_run;
    localparam logic [7:0] reg_ofs [6] = '{`TFS_OFS_FLAGS, `TFS_OFS_SYNC, `TFS_OFS_COUNT,
        `TFS_OFS_CMP_A, `TFS_OFS_CMP_B, `TFS_OFS_ENABLES};

    tfs_timer0 tfs_timer0_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .timer_tick(timer_tick), .overflow_event(overflow_event),
        .global_irq_en(global_irq_en), .vec(vec), .irq_ovf(irq_ovf),
        .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .match_a(match_a), .match_b(match_b),
        .sync_prescaler_reset(sync_prescaler_reset),
        .async_prescaler_reset(async_prescaler_reset), .count_value(count_value));
    tfs_core_model tfs_core_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .irq_ovf(irq_ovf),
        .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .ack_en(ack_en),
        .ack_delay(ack_delay), .vec(vec));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        @(negedge clk_sys);
        chk(rdata, exp);
    endtask : rd

    // One timer clock; match strobes are combinational so sample mid-cycle
    task automatic tick(input logic ovf);
        @(posedge clk_sys);
        timer_tick     <= 1'b1;
        overflow_event <= ovf;
        @(negedge clk_sys);
        hit_a = match_a;
        hit_b = match_b;
        @(posedge clk_sys);
        timer_tick     <= 1'b0;
        overflow_event <= 1'b0;
    endtask : tick

    task automatic wait_quiet;
        int n;
        n = 0;
        @(negedge clk_sys);
        while ((irq_ovf | irq_cmp_a | irq_cmp_b) !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 40) begin
            err_total++;
            $display("wrong value at %0t: request never cleared", $time);
            test_done();
        end
    endtask : wait_quiet

    initial begin
        rst_b = 1'b0; bus = '0; timer_tick = 1'b0; overflow_event = 1'b0;
        global_irq_en = 1'b0; ack_en = 1'b0; ack_delay = 4'h0;
        err_total = 0; tests_run = 0; hit_a = 1'b0; hit_b = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (reg_ofs[i]) rd(1'b0, reg_ofs[i], `TFS_RST_BYTE);
        wr(1'b0, `TFS_OFS_CMP_A, 8'h5A);
        rd(1'b1, `TFS_OFS_CMP_A - `TFS_IO_ALIAS, 8'h5A);
        wr(1'b1, `TFS_OFS_CMP_B - `TFS_IO_ALIAS, 8'hA5);
        rd(1'b0, `TFS_OFS_CMP_B, 8'hA5);
        wr(1'b1, `TFS_OFS_ENABLES - `TFS_IO_ALIAS, 8'h07);
        rd(1'b0, `TFS_OFS_ENABLES, 8'h00);
        rd(1'b0, 8'h50, 8'h00);
        // Counter written only while no tick runs
        wr(1'b0, `TFS_OFS_CMP_A, 8'h05);
        wr(1'b0, `TFS_OFS_CMP_B, 8'h06);
        wr(1'b0, `TFS_OFS_COUNT, 8'h05);
        tick(1'b0); chk({7'h0, hit_a}, 8'h00);
        @(negedge clk_sys); chk(count_value, 8'h06);
        tick(1'b0); chk({7'h0, hit_b}, 8'h01);
        rd(1'b0, `TFS_OFS_FLAGS, 8'h04);
        wr(1'b1, `TFS_OFS_CMP_A - `TFS_IO_ALIAS, 8'h07);
        tick(1'b1); chk({7'h0, hit_a}, 8'h01);
        rd(1'b1, `TFS_OFS_COUNT - `TFS_IO_ALIAS, 8'h08);
        rd(1'b0, `TFS_OFS_FLAGS, 8'h07);
        wr(1'b0, `TFS_OFS_FLAGS, 8'h00);
        rd(1'b0, `TFS_OFS_FLAGS, 8'h07);
        wr(1'b1, `TFS_OFS_FLAGS - `TFS_IO_ALIAS, 8'h02);
        rd(1'b0, `TFS_OFS_FLAGS, 8'h05);
        wr(1'b0, `TFS_OFS_ENABLES, 8'h07);
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h00);
        @(posedge clk_sys); global_irq_en <= 1'b1;
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h05);
        wr(1'b0, `TFS_OFS_ENABLES, 8'h06);
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h04);
        wr(1'b0, `TFS_OFS_ENABLES, 8'h03);
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h01);
        wr(1'b0, `TFS_OFS_FLAGS, 8'h07);
        wr(1'b0, `TFS_OFS_CMP_A, 8'h08);
        tick(1'b0);
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h02);
        // Slow vector, then two back-to-back prompt ones
        @(posedge clk_sys); ack_delay <= 4'h5; ack_en <= 1'b1;
        wait_quiet(); rd(1'b0, `TFS_OFS_FLAGS, 8'h00);
        @(posedge clk_sys); ack_en <= 1'b0; ack_delay <= 4'h0;
        wr(1'b0, `TFS_OFS_ENABLES, 8'h05);
        wr(1'b0, `TFS_OFS_CMP_B, 8'h09);
        tick(1'b1);
        @(negedge clk_sys); chk({5'h0, irq_cmp_b, irq_cmp_a, irq_ovf}, 8'h05);
        @(posedge clk_sys); ack_en <= 1'b1;
        wait_quiet(); rd(1'b0, `TFS_OFS_FLAGS, 8'h00);
        @(posedge clk_sys); ack_en <= 1'b0;
        wr(1'b0, `TFS_OFS_SYNC, 8'h81); repeat (3) @(posedge clk_sys);
        @(negedge clk_sys); chk({6'h0, async_prescaler_reset, sync_prescaler_reset}, 8'h01);
        wr(1'b0, `TFS_OFS_SYNC, 8'h83); repeat (3) @(posedge clk_sys);
        @(negedge clk_sys); chk({6'h0, async_prescaler_reset, sync_prescaler_reset}, 8'h03);
        wr(1'b0, `TFS_OFS_SYNC, 8'h00);
        @(negedge clk_sys); chk({6'h0, async_prescaler_reset, sync_prescaler_reset}, 8'h00);
        wr(1'b0, `TFS_OFS_SYNC, 8'h01);
        @(negedge clk_sys); chk({7'h0, sync_prescaler_reset}, 8'h01);
        @(negedge clk_sys); chk({7'h0, sync_prescaler_reset}, 8'h00);
        test_done();
    end
endmodule : test_tfs_timer0
